// File: design/utx_pkg.sv
package utx_pkg;
    // timing
    localparam int CLK_MHZ = 40;
    localparam int TICK_NS = 6250;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int SYM_PER_TICK_MAX = 16;
    localparam logic [2:0] RATE_MAX = 3'h4;
    localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PREAMBLE = 8'h04;
    localparam logic [7:0] OFF_PRE_LEN = 8'h08;
    localparam logic [7:0] OFF_SEED = 8'h0C;
    localparam logic [7:0] OFF_START = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_LEN = 8'h1C;
    localparam logic [7:0] OFF_SYMS = 8'h20;
    // ctrl fields
    localparam int CTRL_QAM = 0;
    localparam int CTRL_RATE_LO = 1;
    localparam int CTRL_SCR = 4;
    localparam int CTRL_FEC = 5;
    localparam int CTRL_DIFF = 6;
    localparam int CTRL_W = 7;
    localparam int CMD_ARM = 0;
    // scrambler taps, quadrant seed after reset of a burst
    localparam int SCR_TAP_A = 14;
    localparam int SCR_TAP_B = 13;
    localparam logic [1:0] QUAD_INIT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [5:0] PRE_MAX = 6'h20;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_ARM = 2'h3,
        ST_SEND = 2'h2
    } state_t;
endpackage

// File: design/burst_tx.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - bursts start only on a 6,25 us tick boundary, 16 fastest symbols.
// - modulation, rate, preamble, scrambling and FEC are chosen per burst.
// - every burst parameter is software settable and may change per burst.
// - whole burst is buffered, built, then released at its scheduled time.
// - digital section does FEC, preamble prepend and mapping; modulator is stateless.
// - QPSK and 16QAM are both selectable.
// - five symbol rates from 160 to 2 560 ksym/s in both formats.
// - channel symbol rate comes from headend channel descriptor setting.
// - mapper takes the most significant bit of each group first.
// - differential quadrant coding covers every symbol including preamble.
module burst_tx import utx_pkg::*; #(
    parameter int MEM_DEPTH = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic sym_valid,
    output logic [1:0] sym_i,
    output logic [1:0] sym_q
);
    import utx_pkg::*;
    function automatic logic [7:0] xtime(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1D : 8'h00);
    endfunction
    // quadrant code to rotation index: 11,01,00,10 step by 90 degrees
    function automatic logic [1:0] quad_idx(input logic [1:0] q);
        return {~q[0], q[1] ^ q[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    state_t st_q, st_d;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d, cfg_q, cfg_d;
    logic [31:0] pre_q, pre_d, bpre_q, bpre_d;
    logic [5:0] plen_q, plen_d, bplen_q, bplen_d;
    logic [14:0] seed_q, seed_d, lfsr_q, lfsr_d;
    logic [15:0] start_q, start_d, slot_q, slot_d;
    logic [7:0] len_q, len_d, blen_q, blen_d, wptr_q, wptr_d;
    logic [7:0] par1_q, par1_d, par0_q, par0_d;
    logic [8:0] ph_q, ph_d, acc_q, acc_d;
    logic [11:0] bptr_q, bptr_d;
    logic [1:0] quad_q, quad_d;
    logic [1:0] si_q, si_d, sq_q, sq_d;
    logic sv_q, sv_d, bv_q, bv_d, rv_q, rv_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] mem [MEM_DEPTH];

    logic wr_go, rd_go, arm_wr, take, strobe, tick_edge;
    logic [8:0] inc;
    logic [2:0] bps;
    logic [11:0] nbits;
    logic [15:0] nsyms;
    logic [3:0] bits;
    logic [7:0] fb;

    assign inc = 9'(1) << cfg_q[CTRL_RATE_LO +: 3];
    assign bps = cfg_q[CTRL_QAM] ? 3'h4 : 3'h2;
    assign nbits = 12'(bplen_q) + 12'((12'(blen_q) + (cfg_q[CTRL_FEC] ? 12'h002 : 12'h000)) << 3);  // no wrap at 255
    assign nsyms = 16'((nbits + 12'(bps) - 12'h001) / 12'(bps));
    assign tick_edge = (ph_q == 9'h000);
    assign strobe = (acc_q < inc);
    assign take = (st_q == ST_LOAD) && in_valid && ce;
    assign in_ready = (st_q == ST_LOAD) && ce;
    assign fb = in_data ^ par1_q;

    ////////////////////////////////////////////////////////////////////////
    // register bus: address and data are taken together
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bv_q && ce;
    assign rd_go = s_axi_arvalid && !rv_q && ce;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign arm_wr = wr_go && (s_axi_awaddr == OFF_CMD) && s_axi_wstrb[0] && s_axi_wdata[CMD_ARM];

    always_comb begin
        ctrl_d = ctrl_q;
        pre_d = pre_q;
        plen_d = plen_q;
        seed_d = seed_q;
        start_d = start_q;
        len_d = len_q;
        bv_d = bv_q && !s_axi_bready;
        bresp_d = bresp_q;
        rv_d = rv_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (wr_go) begin
            bv_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case (s_axi_awaddr)
                OFF_CTRL: if (s_axi_wstrb[0]) ctrl_d = s_axi_wdata[CTRL_W-1:0];
                OFF_PREAMBLE: pre_d = s_axi_wdata;
                OFF_PRE_LEN: if (s_axi_wdata[5:0] <= PRE_MAX) plen_d = s_axi_wdata[5:0];
                OFF_SEED: seed_d = s_axi_wdata[14:0];
                OFF_START: start_d = s_axi_wdata[15:0];
                OFF_LEN: len_d = s_axi_wdata[7:0];
                OFF_CMD, OFF_STATUS, OFF_SYMS: ;
                default: bresp_d = RESP_DECERR;
            endcase
        end
        if (rd_go) begin
            rv_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (s_axi_araddr)
                OFF_CTRL: rdata_d = 32'(ctrl_q);
                OFF_PREAMBLE: rdata_d = pre_q;
                OFF_PRE_LEN: rdata_d = 32'(plen_q);
                OFF_SEED: rdata_d = 32'(seed_q);
                OFF_START: rdata_d = 32'(start_q);
                OFF_LEN: rdata_d = 32'(len_q);
                OFF_CMD: rdata_d = 32'h0000_0000;
                OFF_STATUS: rdata_d = {slot_q, 14'h0000, st_q};
                OFF_SYMS: rdata_d = 32'(nsyms);
                default: rresp_d = RESP_DECERR;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slot clock and symbol strobe: 1, 2, 4, 8 or 16 symbols per tick; first strobe one cycle after the tick edge,
    // so a burst that starts on the edge sends its first symbol at once
    always_comb begin
        ph_d = (ph_q == TICK_LAST) ? 9'h000 : ph_q + 9'h001;
        slot_d = (ph_q == TICK_LAST) ? slot_q + 16'h0001 : slot_q;
        acc_d = tick_edge ? 9'h000 : 9'((acc_q + inc) % 9'(TICK_CYC));
    end

    ////////////////////////////////////////////////////////////////////////
    // burst sequencer, loader, encoder and mapper
    always_comb begin
        logic b;
        logic [11:0] k;
        logic [7:0] byt;
        logic [14:0] s;
        logic [1:0] qn;
        b = 1'b0;
        k = 12'h000;
        byt = 8'h00;
        st_d = st_q;
        cfg_d = cfg_q;
        bpre_d = bpre_q;
        bplen_d = bplen_q;
        blen_d = blen_q;
        lfsr_d = lfsr_q;
        wptr_d = wptr_q;
        par1_d = par1_q;
        par0_d = par0_q;
        bptr_d = bptr_q;
        quad_d = quad_q;
        si_d = si_q;
        sq_d = sq_q;
        sv_d = 1'b0;
        bits = 4'h0;
        s = lfsr_q;
        for (int n = 0; n < 4; n++) begin
            k = bptr_q + 12'(n);
            byt = 8'h00;
            if (k < 12'(bplen_q)) begin
                b = bpre_q[31 - k[4:0]];
            end else begin
                k = k - 12'(bplen_q);
                if (k[11:3] < 9'(blen_q)) byt = mem[k[10:3]];
                else if (k[11:3] == 9'(blen_q)) byt = par1_q;
                else byt = par0_q;
                b = (k < nbits - 12'(bplen_q)) ? byt[3'h7 - k[2:0]] : 1'b0;
                if (cfg_q[CTRL_SCR] && n < int'(bps)) begin
                    b = b ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
                    s = {s[13:0], s[SCR_TAP_A] ^ s[SCR_TAP_B]};
                end
            end
            if (n < int'(bps)) bits[3 - n] = b;
        end
        // quadrant rotation by input bits 00/01/11/10 = 0/90/180/270 degrees
        qn = quad_idx(quad_q) + {bits[3], bits[3] ^ bits[2]};
        unique case (st_q)
            ST_IDLE: if (arm_wr) begin
                st_d = ST_LOAD;
                cfg_d = ctrl_q;
                bpre_d = pre_q;
                bplen_d = plen_q;
                blen_d = len_q;
                lfsr_d = seed_q;
                wptr_d = 8'h00;
                par1_d = 8'h00;
                par0_d = 8'h00;
            end
            ST_LOAD: if (blen_q == 8'h00) begin
                st_d = ST_ARM;
            end else if (take) begin
                wptr_d = wptr_q + 8'h01;
                // shortened RS T=1 code, g(x) = x^2 + 3x + 2
                par1_d = par0_q ^ xtime(fb) ^ fb;
                par0_d = xtime(fb);
                if (wptr_q == blen_q - 8'h01) st_d = ST_ARM;
            end
            ST_ARM: if (tick_edge && slot_q == start_q) begin
                st_d = ST_SEND;
                bptr_d = 12'h000;
                quad_d = QUAD_INIT;
            end
            ST_SEND: if (strobe) begin
                sv_d = 1'b1;
                bptr_d = bptr_q + 12'(bps);
                lfsr_d = s;
                quad_d = cfg_q[CTRL_DIFF] ? {~(qn[1] ^ qn[0]), ~qn[1]} : {bits[3], bits[2]};
                si_d = {quad_d[1], cfg_q[CTRL_QAM] & bits[1]};
                sq_d = {quad_d[0], cfg_q[CTRL_QAM] & bits[0]};
                if (bptr_q + 12'(bps) >= nbits) st_d = ST_IDLE;
            end
        endcase
    end

    assign sym_valid = sv_q;
    assign sym_i = si_q;
    assign sym_q = sq_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            ctrl_q <= '0;
            cfg_q <= '0;
            pre_q <= 32'h0000_0000;
            bpre_q <= 32'h0000_0000;
            plen_q <= 6'h00;
            bplen_q <= 6'h00;
            seed_q <= 15'h0000;
            lfsr_q <= 15'h0000;
            start_q <= 16'h0000;
            slot_q <= 16'h0000;
            len_q <= 8'h00;
            blen_q <= 8'h00;
            wptr_q <= 8'h00;
            par1_q <= 8'h00;
            par0_q <= 8'h00;
            ph_q <= 9'h000;
            acc_q <= TICK_LAST;  // no strobe before the first tick edge
            bptr_q <= 12'h000;
            quad_q <= QUAD_INIT;
            si_q <= 2'h0;
            sq_q <= 2'h0;
            sv_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            pre_q <= pre_d;
            bpre_q <= bpre_d;
            plen_q <= plen_d;
            bplen_q <= bplen_d;
            seed_q <= seed_d;
            lfsr_q <= lfsr_d;
            start_q <= start_d;
            slot_q <= slot_d;
            len_q <= len_d;
            blen_q <= blen_d;
            wptr_q <= wptr_d;
            par1_q <= par1_d;
            par0_q <= par0_d;
            ph_q <= ph_d;
            acc_q <= acc_d;
            bptr_q <= bptr_d;
            quad_q <= quad_d;
            si_q <= si_d;
            sq_q <= sq_d;
            sv_q <= sv_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // burst store has no reset; contents are only read after a full load
    always_ff @(posedge aclk) begin
        if (take) mem[wptr_q] <= in_data;
    end

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] scnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) scnt_q <= 5'h00;
        else if (ce) scnt_q <= tick_edge ? 5'(strobe) : scnt_q + 5'(strobe);
    end

    chk_no_idle_sym: assert property (@(posedge aclk) disable iff (!aresetn) ce && sv_d |-> st_q == ST_SEND) else $error("symbol outside burst");
    chk_start_slot: assert property (@(posedge aclk) disable iff (!aresetn) ce && st_q == ST_ARM && st_d == ST_SEND |-> tick_edge && slot_q == start_q) else $error("burst off slot");
    chk_tick_count: assert property (@(posedge aclk) disable iff (!aresetn) ce && st_q == ST_SEND && ph_q == TICK_LAST |-> scnt_q + 5'(strobe) == 5'(inc)) else $error("wrong symbols per tick");
    chk_cfg_hold: assert property (@(posedge aclk) disable iff (!aresetn) ce && st_q == ST_SEND ##1 ce |-> $stable(cfg_q)) else $error("burst settings changed");
    chk_qpsk_lsb: assert property (@(posedge aclk) disable iff (!aresetn) sv_q && !cfg_q[CTRL_QAM] |-> si_q[0] == 1'b0 && sq_q[0] == 1'b0) else $error("qpsk low bits set");
    chk_rate_legal: assert property (@(posedge aclk) disable iff (!aresetn) st_q == ST_SEND |-> cfg_q[CTRL_RATE_LO +: 3] <= RATE_MAX) else $error("illegal rate");
    chk_load_full: assert property (@(posedge aclk) disable iff (!aresetn) ce && st_q == ST_LOAD && st_d == ST_ARM |-> blen_q == 8'h00 || wptr_q == blen_q - 8'h01) else $error("early release");
    chk_diff_stay: assert property (@(posedge aclk) disable iff (!aresetn) ce && st_q == ST_SEND && strobe && cfg_q[CTRL_DIFF] && bits[3:2] == 2'h0 |=> quad_q == $past(quad_q)) else $error("zero rotation moved quadrant");
    chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn) bv_q && !s_axi_bready |=> bv_q) else $error("write answer dropped");
    cov_qam_burst: cover property (@(posedge aclk) st_q == ST_ARM && st_d == ST_SEND && cfg_q[CTRL_QAM]);
    cov_fec_end: cover property (@(posedge aclk) st_q == ST_SEND && st_d == ST_IDLE && cfg_q[CTRL_FEC]);
    cov_diff_sym: cover property (@(posedge aclk) sv_q && cfg_q[CTRL_DIFF]);
endmodule

// File: test/headend_rx.sv
`timescale 1ns/1ps
module headend_rx (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic [8:0] gate_len,
    input wire logic sym_valid,
    input wire logic [1:0] sym_i,
    input wire logic [1:0] sym_q
);
    logic [3:0] log_q [64];
    int got;
    int stray;
    int cyc = 0;
    int first_cyc;
    int last_cyc;
    int min_gap;
    int max_gap;
    logic burst_ok;
    ////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (!aresetn) begin
            stray <= 0;
        end
        if (!aresetn || clear) begin
            got <= 0;
            min_gap <= 100000;
            max_gap <= 0;
        end else if (sym_valid === 1'b1) begin
            // acquisition gate stays open only for the announced length
            if (got < gate_len) begin
                if (got < 64) begin
                    log_q[got] <= {sym_i, sym_q}; // both formats logged
                end
                if (got == 0) begin
                    first_cyc <= cyc;
                end else begin
                    min_gap <= (cyc - last_cyc < min_gap) ? cyc - last_cyc : min_gap;
                    max_gap <= (cyc - last_cyc > max_gap) ? cyc - last_cyc : max_gap;
                end
                last_cyc <= cyc;
                got <= got + 1;
            end else begin
                stray <= stray + 1;
            end
        end
    end
    // decode report: the burst is whole once the announced count arrived; symbols beyond it only count as stray
    assign burst_ok = (got == gate_len);
endmodule

// File: test/test_upstream_burst_tx_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_upstream_burst_tx_control;
    import utx_pkg::*;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic in_valid, in_ready, sym_valid, clear;
    logic [7:0] s_axi_awaddr, s_axi_araddr, in_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, sym_i, sym_q;
    logic [8:0] gate_len;
    logic [47:0] stream = 48'hB4E12D87C63A;
    int num_errors = 0;
    int compares = 0;
    int start_a;
    burst_tx burst_tx_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .in_data, .in_valid, .in_ready, .sym_valid, .sym_i, .sym_q);
    headend_rx headend_rx_inst (.aclk, .aresetn, .clear, .gate_len, .sym_valid, .sym_i, .sym_q);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        $display("BAD t=%0t got=%0h exp=%0h", $time, 0, 1);
        print_verdict();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_awready !== 1'b1 && n < 200);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        // one idle edge keeps the next call from driving bready again in this time step
        @(posedge aclk);
        if (n >= 200) hang();
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 200);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        if (n >= 200) hang();
    endtask
    // one whole burst: schedule, configure, arm, load, then watch it on air
    task automatic run_burst(input logic [31:0] ctrl, input logic [31:0] pre_len, input logic [7:0] b0,
        input int nbytes, input logic [8:0] nsym);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        axi_rd(OFF_STATUS, d, r);
        axi_wr(OFF_START, {16'h0, d[31:16] + 16'h2}, r); // two ticks ahead leaves the guard
        axi_wr(OFF_CTRL, ctrl, r);
        axi_wr(OFF_PREAMBLE, 32'hB4E12D87, r);
        axi_wr(OFF_PRE_LEN, pre_len, r);
        axi_wr(OFF_LEN, 32'(nbytes), r);
        `CHK(in_ready, 1'b0)
        axi_wr(OFF_CMD, 32'h1, r);
        axi_rd(OFF_SYMS, d, r);
        `CHK(d[8:0], nsym)
        gate_len <= nsym;
        clear <= 1'b1;
        @(posedge aclk);
        clear <= 1'b0;
        for (int k = 0; k < nbytes; k++) begin
            in_data <= (k == 0) ? b0 : stream[7:0];
            in_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while (in_ready !== 1'b1 && n < 100);
            if (n >= 100) hang();
        end
        in_valid <= 1'b0;
        n = 0;
        while (headend_rx_inst.got < nsym && n < 4000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 4000) hang();
        repeat (40) @(posedge aclk);
        `CHK(headend_rx_inst.burst_ok, 1'b1)
        axi_rd(OFF_STATUS, d, r);
        `CHK(d[1:0], 2'(ST_IDLE))
    endtask
    ////////////////////////////////////////////////////////////
    task automatic scen_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(OFF_CTRL, d, r);
        `CHK(d, 32'h0)
        axi_wr(OFF_PRE_LEN, 32'h10, r);
        axi_wr(OFF_PRE_LEN, 32'h21, r);
        axi_rd(OFF_PRE_LEN, d, r);
        `CHK(d, 32'h10)
        axi_wr(8'h40, 32'h1, r);
        `CHK(r, RESP_DECERR)
        axi_rd(8'h40, d, r);
        `CHK({r, d}, {RESP_DECERR, 32'h0})
    endtask
    task automatic scen_map();
        run_burst(32'h08, 32'h20, 8'hC6, 2, 9'h18);
        start_a = headend_rx_inst.first_cyc;
        for (int k = 0; k < 24; k++) begin
            `CHK({headend_rx_inst.log_q[k][3], headend_rx_inst.log_q[k][1]}, stream[47 - 2 * k -: 2])
        end
        `CHK(headend_rx_inst.max_gap <= 16, 1'b1)
    endtask
    task automatic scen_diff();
        logic [1:0] q;
        logic [3:0] nib;
        q = QUAD_INIT;
        stream[7:0] = 8'h3A;
        run_burst(32'h47, 32'h20, 8'hC6, 2, 9'h0C);
        `CHK((headend_rx_inst.first_cyc - start_a) % 250, 0)
        for (int k = 0; k < 12; k++) begin
            nib = stream[47 - 4 * k -: 4];
            repeat ({nib[3], nib[3] ^ nib[2]}) q = {~q[0], q[1]};
            `CHK(headend_rx_inst.log_q[k], {q[1], nib[1], q[0], nib[0]})
        end
    endtask
    task automatic scen_rates();
        logic [8:0] nsym;
        logic [23:0] par;
        // one byte m under g(x) = x^2 + 3x + 2 leaves parity 3m then 2m
        par = {8'h5A, 8'hEE, 8'hB4};
        for (int r = 0; r < 5; r++) begin
            nsym = 9'((r == 2 ? 24 : 8) / (r % 2 == 1 ? 4 : 2));
            run_burst(32'((r == 2 ? 32 : 0) + r * 2 + r % 2), 32'h0, 8'h5A, 1, nsym);
            `CHK(headend_rx_inst.max_gap <= ((250 + (1 << r) - 1) >> r), 1'b1)
            `CHK(headend_rx_inst.min_gap >= (250 >> r), 1'b1)
            if (r == 2) begin
                for (int k = 0; k < 12; k++) begin
                    `CHK({headend_rx_inst.log_q[k][3], headend_rx_inst.log_q[k][1]}, par[23 - 2 * k -: 2])
                end
            end
        end
    endtask
    task automatic scen_scr();
        logic [14:0] s;
        logic [7:0] v;
        logic [7:0] x;
        logic [1:0] r;
        s = 15'h4A5B;
        v = 8'hA5;
        axi_wr(OFF_SEED, 32'(s), r);
        run_burst(32'h18, 32'h0, v, 1, 9'h04);
        // payload bits in send order, each xored with the two scrambler taps
        for (int k = 7; k >= 0; k--) begin
            x[k] = v[k] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
            s = {s[13:0], s[SCR_TAP_A] ^ s[SCR_TAP_B]};
        end
        for (int k = 0; k < 4; k++) begin
            `CHK({headend_rx_inst.log_q[k][3], headend_rx_inst.log_q[k][1]}, x[7 - 2 * k -: 2])
        end
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {in_valid, clear, s_axi_awaddr, s_axi_araddr, in_data, s_axi_wdata, gate_len} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        scen_regs();
        scen_map();
        scen_diff();
        scen_rates();
        scen_scr();
        `CHK(headend_rx_inst.stray, 0)
        print_verdict();
    end
endmodule
